// ---- include/iop_pkg.sv ----
package iop_pkg;
	// Register word indices; byte address is index times four
	localparam logic [3:0] IOP_IDX_PA_DATA = 4'h0;
	localparam logic [3:0] IOP_IDX_PA_DIR = 4'h1;
	localparam logic [3:0] IOP_IDX_PA_WAKE = 4'h2;
	localparam logic [3:0] IOP_IDX_PA_PULL = 4'h3;
	localparam logic [3:0] IOP_IDX_PB_DATA = 4'h4;
	localparam logic [3:0] IOP_IDX_PB_DIR = 4'h5;
	localparam logic [3:0] IOP_IDX_PB_PULL = 4'h6;
	localparam logic [3:0] IOP_IDX_SYSCTL0 = 4'h7;
	localparam logic [3:0] IOP_IDX_SLEEP = 4'h8;
	// Access alias in address bits 7:6
	localparam logic [1:0] IOP_OP_WRITE = 2'h0;
	localparam logic [1:0] IOP_OP_SET = 2'h1;
	localparam logic [1:0] IOP_OP_CLEAR = 2'h2;
	localparam int IOP_IDX_LSB = 2;
	localparam int IOP_OP_LSB = 6;
	// system_control_0 fields
	localparam int IOP_CTL_DIV_SRC = 6;
	localparam int IOP_CTL_PWM_TYPE = 5;
	localparam int IOP_CTL_PWM_PIN = 3;
	localparam int IOP_CTL_DIV_PIN = 2;
	localparam int IOP_CTL_XTAL_LP = 1;
	localparam int IOP_CTL_CLK_SEL = 0;
	localparam logic [7:0] IOP_CTL_MASK = 8'h6f;
	localparam logic [7:0] IOP_CTL_RESET = 8'h00;
	// Port resets: all pins inputs, data latches clear
	localparam logic [7:0] IOP_DIR_RESET = 8'hff;
	localparam logic [7:0] IOP_DATA_RESET = 8'h00;
	localparam logic [7:0] IOP_SEL_RESET = 8'h00;
	localparam int IOP_SLEEP_BIT = 0;
	localparam logic [1:0] IOP_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] IOP_HTRANS_SEQ = 2'h3;
	localparam logic [2:0] IOP_HSIZE_WORD = 3'h2;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [1:0] op;
		logic [3:0] idx;
	} iop_req_s;

	typedef enum logic [1:0] {
		IOP_RUN = 2'b00,
		IOP_ASLEEP = 2'b01,
		IOP_WAKING = 2'b11
	} iop_power_e;
endpackage

// ---- verilog/iop_pin_sync.sv ----
`timescale 1ns/1ns
module iop_pin_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					meta_r[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					meta_r[i] <= async_in[i];
					sync_out[i] <= meta_r[i];
				end
			end
		end
	endgenerate
endmodule

// ---- verilog/iop_ahb_slave.sv ----
`timescale 1ns/1ns
module iop_ahb_slave
	import iop_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	// Register side, valid during the data phase
	output iop_req_s req
);
	logic take;

	// Only whole-word transfers reach the registers
	assign take = hsel && hready && hsize == IOP_HSIZE_WORD &&
		(htrans == IOP_HTRANS_NONSEQ || htrans == IOP_HTRANS_SEQ);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req <= '0;
		end else begin
			req.wr <= take && hwrite;
			req.rd <= take && !hwrite;
			if (take) begin
				req.op <= haddr[IOP_OP_LSB +: 2];
				req.idx <= haddr[IOP_IDX_LSB +: 4];
			end
		end
	end

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
endmodule

// ---- verilog/iop_top.sv ----
`timescale 1ns/1ns
module iop_top
	import iop_pkg::*;
#(
	parameter int PA_W = 8,
	parameter int PB_W = 2,
	parameter int DIV_PIN = 0,
	parameter int PWM_PIN = 1
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Port A pins
	input wire logic [PA_W-1:0] pa_in,
	output logic [PA_W-1:0] pa_out,
	output logic [PA_W-1:0] pa_oe,
	output logic [PA_W-1:0] pa_pullup_en,
	// Port B pins
	input wire logic [PB_W-1:0] pb_in,
	output logic [PB_W-1:0] pb_out,
	output logic [PB_W-1:0] pb_oe,
	output logic [PB_W-1:0] pb_pullup_en,
	// Peripheral signals sharing port B pins
	input wire logic divider_out,
	input wire logic pwm_out,
	// Oscillator configuration option, static
	input wire logic option_rc_plus_crystal,
	// Clock and peripheral controls
	output logic divider_clock_source,
	output logic pwm_type_select,
	output logic crystal_low_power,
	output logic system_clock_select,
	output logic internal_rc_enable,
	// Power state
	output logic sleep_mode,
	output logic wake_pulse
);
	iop_req_s req;
	logic [7:0] wdata;
	logic [7:0] port_a_data_r;
	logic [7:0] port_a_direction_r;
	logic [7:0] port_a_wake_enable_r;
	logic [7:0] port_a_pullup_select_r;
	logic [7:0] port_b_data_r;
	logic [7:0] port_b_direction_r;
	logic [7:0] port_b_pullup_select_r;
	logic [7:0] system_control_0_r;
	logic [PA_W-1:0] pa_sync;
	logic [PA_W-1:0] pa_prev_r;
	logic [PB_W-1:0] pb_sync;
	logic [0:0] option_sync;
	logic [PA_W-1:0] pa_fall;
	logic wake_hit;
	logic sleep_wr;
	logic [7:0] sleep_val;
	logic [7:0] rdata;
	iop_power_e power_r;
	iop_power_e power_nxt;

	iop_ahb_slave u_slave (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.req(req)
	);

	iop_pin_sync #(.W(PA_W)) u_sync_a (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(pa_in),
		.sync_out(pa_sync)
	);

	iop_pin_sync #(.W(PB_W)) u_sync_b (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(pb_in),
		.sync_out(pb_sync)
	);

	iop_pin_sync #(.W(1)) u_sync_opt (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(option_rc_plus_crystal),
		.sync_out(option_sync)
	);

	assign wdata = hwdata[7:0];

	// Plain write, or set / clear of the bits written as one
	function automatic logic [7:0] iop_apply(
		input logic [1:0] op,
		input logic [7:0] cur,
		input logic [7:0] val
	);
		logic [7:0] res;
		res = cur;
		if (op == IOP_OP_WRITE) begin
			res = val;
		end else if (op == IOP_OP_SET) begin
			res = cur | val;
		end else if (op == IOP_OP_CLEAR) begin
			res = cur & ~val;
		end
		return res;
	endfunction

	function automatic logic hit(
		input iop_req_s r,
		input logic [3:0] idx
	);
		return r.wr && r.idx == idx;
	endfunction

	// Port A data latch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_a_data_r <= IOP_DATA_RESET;
		end else if (hit(req, IOP_IDX_PA_DATA)) begin
			port_a_data_r <= iop_apply(req.op, port_a_data_r, wdata);
		end
	end

	// Port A direction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_a_direction_r <= IOP_DIR_RESET;
		end else if (hit(req, IOP_IDX_PA_DIR)) begin
			port_a_direction_r <= iop_apply(req.op, port_a_direction_r, wdata);
		end
	end

	// Port A wake enables
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_a_wake_enable_r <= IOP_SEL_RESET;
		end else if (hit(req, IOP_IDX_PA_WAKE)) begin
			port_a_wake_enable_r <= iop_apply(req.op, port_a_wake_enable_r, wdata);
		end
	end

	// Port A pull-high selects
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_a_pullup_select_r <= IOP_SEL_RESET;
		end else if (hit(req, IOP_IDX_PA_PULL)) begin
			port_a_pullup_select_r <= iop_apply(req.op, port_a_pullup_select_r, wdata);
		end
	end

	// Port B data latch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_b_data_r <= IOP_DATA_RESET;
		end else if (hit(req, IOP_IDX_PB_DATA)) begin
			port_b_data_r <= iop_apply(req.op, port_b_data_r, wdata);
		end
	end

	// Port B direction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_b_direction_r <= IOP_DIR_RESET;
		end else if (hit(req, IOP_IDX_PB_DIR)) begin
			port_b_direction_r <= iop_apply(req.op, port_b_direction_r, wdata);
		end
	end

	// Port B pull-high selects
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_b_pullup_select_r <= IOP_SEL_RESET;
		end else if (hit(req, IOP_IDX_PB_PULL)) begin
			port_b_pullup_select_r <= iop_apply(req.op, port_b_pullup_select_r, wdata);
		end
	end

	// System control; unimplemented bits never store
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			system_control_0_r <= IOP_CTL_RESET;
		end else if (hit(req, IOP_IDX_SYSCTL0)) begin
			system_control_0_r <=
				iop_apply(req.op, system_control_0_r, wdata) & IOP_CTL_MASK;
		end
	end

	// Falling edges seen only after both sync stages
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pa_prev_r <= '0;
		end else begin
			pa_prev_r <= pa_sync;
		end
	end

	assign pa_fall = pa_prev_r & ~pa_sync;
	assign wake_hit = |(pa_fall & port_a_wake_enable_r[PA_W-1:0]);
	// Only the sleep bit counts, so stray upper bits cannot put the core to sleep
	assign sleep_val = iop_apply(req.op, {7'h00, sleep_mode}, wdata);
	assign sleep_wr = hit(req, IOP_IDX_SLEEP) && sleep_val[IOP_SLEEP_BIT];

	// Power state; a wake edge counts only while asleep, so a sleep write in run mode always takes effect
	always_comb begin
		power_nxt = power_r;
		case (power_r)
			IOP_RUN: begin
				if (sleep_wr) begin
					power_nxt = IOP_ASLEEP;
				end
			end
			IOP_ASLEEP: begin
				if (wake_hit) begin
					power_nxt = IOP_WAKING;
				end
			end
			IOP_WAKING: begin
				power_nxt = IOP_RUN;
			end
			default: begin
				power_nxt = IOP_RUN;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			power_r <= IOP_RUN;
		end else begin
			power_r <= power_nxt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_mode <= 1'b0;
			wake_pulse <= 1'b0;
		end else begin
			sleep_mode <= power_nxt == IOP_ASLEEP;
			wake_pulse <= power_nxt == IOP_WAKING;
		end
	end

	// Port A pins
	always_comb begin
		pa_out = port_a_data_r[PA_W-1:0];
		pa_oe = ~port_a_direction_r[PA_W-1:0];
		pa_pullup_en = port_a_direction_r[PA_W-1:0] &
			port_a_pullup_select_r[PA_W-1:0];
	end

	// Port B pins; a peripheral takes its pin whatever the direction bit says
	always_comb begin
		pb_out = port_b_data_r[PB_W-1:0];
		pb_oe = ~port_b_direction_r[PB_W-1:0];
		pb_pullup_en = port_b_direction_r[PB_W-1:0] &
			port_b_pullup_select_r[PB_W-1:0];
		if (system_control_0_r[IOP_CTL_DIV_PIN]) begin
			pb_out[DIV_PIN] = divider_out;
			pb_oe[DIV_PIN] = 1'b1;
			pb_pullup_en[DIV_PIN] = 1'b0;
		end
		if (system_control_0_r[IOP_CTL_PWM_PIN]) begin
			pb_out[PWM_PIN] = pwm_out;
			pb_oe[PWM_PIN] = 1'b1;
			pb_pullup_en[PWM_PIN] = 1'b0;
		end
	end

	// Clock and peripheral controls
	assign divider_clock_source = system_control_0_r[IOP_CTL_DIV_SRC];
	assign pwm_type_select = system_control_0_r[IOP_CTL_PWM_TYPE];
	assign crystal_low_power = system_control_0_r[IOP_CTL_XTAL_LP];
	// Without the RC plus crystal option the bit is ignored
	assign system_clock_select =
		system_control_0_r[IOP_CTL_CLK_SEL] & option_sync[0];
	assign internal_rc_enable = ~system_clock_select;

	// Read mux; data registers return pin levels, not the latch
	always_comb begin
		rdata = 8'h00;
		// Set and clear aliases are write-only views
		if (req.op != IOP_OP_WRITE) begin
			rdata = 8'h00;
		end else if (req.idx == IOP_IDX_PA_DATA) begin
			rdata[PA_W-1:0] = pa_sync;
		end else if (req.idx == IOP_IDX_PA_DIR) begin
			rdata = port_a_direction_r;
		end else if (req.idx == IOP_IDX_PA_WAKE) begin
			rdata = port_a_wake_enable_r;
		end else if (req.idx == IOP_IDX_PA_PULL) begin
			rdata = port_a_pullup_select_r;
		end else if (req.idx == IOP_IDX_PB_DATA) begin
			rdata[PB_W-1:0] = pb_sync;
		end else if (req.idx == IOP_IDX_PB_DIR) begin
			rdata[PB_W-1:0] = port_b_direction_r[PB_W-1:0];
		end else if (req.idx == IOP_IDX_PB_PULL) begin
			rdata[PB_W-1:0] = port_b_pullup_select_r[PB_W-1:0];
		end else if (req.idx == IOP_IDX_SYSCTL0) begin
			rdata = system_control_0_r;
		end else if (req.idx == IOP_IDX_SLEEP) begin
			rdata[IOP_SLEEP_BIT] = sleep_mode;
		end
	end

	assign hrdata = req.rd ? {24'h000000, rdata} : 32'h00000000;
endmodule

// ---- testbench/iop_pin_model.sv ----
`timescale 1ns/1ns
module iop_pin_model #(
	parameter int W = 8
) (
	// Clock
	input wire logic clk,
	// Device side
	input wire logic [W-1:0] drv,
	input wire logic [W-1:0] oe,
	input wire logic [W-1:0] pull,
	// Outside circuitry
	input wire logic [W-1:0] ext,
	input wire logic [W-1:0] ext_en,
	// Pin levels
	output logic [W-1:0] pin
);
	logic [W-1:0] flt_r = '0;
	// Floating pins wander, so a stale level is never trusted
	always @(posedge clk) flt_r <= ~flt_r;
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (oe[i]) pin[i] = drv[i];
			else if (ext_en[i]) pin[i] = ext[i];
			else if (pull[i]) pin[i] = 1'b1;
			else pin[i] = flt_r[i];
		end
	end
endmodule

// ---- testbench/iop_top_chk.sv ----
`timescale 1ns/1ns
module iop_top_chk
	import iop_pkg::*;
#(
	parameter int PA_W = 8,
	parameter int PB_W = 2
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	// Pins
	input wire logic [PA_W-1:0] pa_in,
	input wire logic [PA_W-1:0] pa_out,
	input wire logic [PA_W-1:0] pa_oe,
	input wire logic [PA_W-1:0] pa_pullup_en,
	input wire logic [PB_W-1:0] pb_oe,
	input wire logic [PB_W-1:0] pb_pullup_en,
	// Controls
	input wire logic option_rc_plus_crystal,
	input wire logic divider_clock_source,
	input wire logic pwm_type_select,
	input wire logic crystal_low_power,
	input wire logic system_clock_select,
	input wire logic internal_rc_enable,
	input wire logic sleep_mode,
	input wire logic wake_pulse
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_acc(logic [31:0] a, logic w);
		hsel && hready && htrans == IOP_HTRANS_NONSEQ && hsize == IOP_HSIZE_WORD
			&& hwrite == w && haddr == a;
	endsequence
	chk_pull_input: assert property (
		(pa_pullup_en & pa_oe) == '0 && (pb_pullup_en & pb_oe) == '0) else $error("pull on output");
	chk_rc_stop: assert property (
		internal_rc_enable != system_clock_select
		&& (!system_clock_select || $past(option_rc_plus_crystal, 2))) else $error("rc enable wrong");
	chk_option_gate: assert property (
		(!option_rc_plus_crystal)[*3] |-> !system_clock_select) else $error("clock select ungated");
	chk_dir_write: assert property (
		s_acc(32'h04, 1) |-> ##2 pa_oe == ~$past(hwdata[PA_W-1:0])) else $error("direction write");
	chk_data_write: assert property (
		s_acc(32'h00, 1) |-> ##2 pa_out == $past(hwdata[PA_W-1:0])) else $error("data write");
	chk_dir_set: assert property (
		s_acc(32'h44, 1) |-> ##2 pa_oe == ($past(pa_oe) & ~$past(hwdata[PA_W-1:0])))
		else $error("direction set");
	chk_data_clear: assert property (
		s_acc(32'h80, 1) |-> ##2 pa_out == ($past(pa_out) & ~$past(hwdata[PA_W-1:0])))
		else $error("data clear");
	chk_ctl_write: assert property (
		s_acc(32'h1c, 1) |-> ##2 {divider_clock_source, pwm_type_select, crystal_low_power}
		== {$past(hwdata[6]), $past(hwdata[5]), $past(hwdata[1])}) else $error("control write");
	chk_ctl_read: assert property (
		s_acc(32'h1c, 0) |-> ##1 hrdata[31:7] == '0 && !hrdata[4] && hrdata[6] == divider_clock_source
		&& hrdata[1] == crystal_low_power) else $error("control read");
	chk_wake_cause: assert property (
		wake_pulse |-> $past(sleep_mode) && !sleep_mode && ((|($past(pa_in, 5) & ~$past(pa_in, 4)))
		|| (|($past(pa_in, 4) & ~$past(pa_in, 3))))) else $error("wake without pin fall");
	chk_sleep_exit: assert property (
		$fell(sleep_mode) |-> wake_pulse) else $error("sleep left silently");
endmodule
bind iop_top iop_top_chk #(.PA_W(PA_W), .PB_W(PB_W)) u_chk (.*);

// ---- testbench/tb.sv ----
`timescale 1ns/1ns
module tb;
	import iop_pkg::*;
	logic hclk = 0;
	logic hresetn = 0;
	logic hsel = 0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 0;
	logic [2:0] hsize = IOP_HSIZE_WORD;
	logic [31:0] hwdata = '0;
	logic hreadyout, hresp, rdy_q;
	logic [31:0] hrdata, rd_q, rd;
	logic [7:0] pa_in, pa_out, pa_oe, pa_pu;
	logic [7:0] pa_ext = '0;
	logic [7:0] pa_en = '0;
	logic [1:0] pb_in, pb_out, pb_oe, pb_pu;
	logic div_o = 1;
	logic pwm_o = 1;
	logic opt = 1;
	logic dcs, pts, clp, scs, rce, slp, wk;
	int bad_count = 0;
	int total_checks = 0;
	always #2 hclk = ~hclk;
	always @(posedge hclk) begin
		rd_q <= hrdata;
		rdy_q <= hreadyout;
	end
	iop_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pa_in(pa_in), .pa_out(pa_out),
		.pa_oe(pa_oe), .pa_pullup_en(pa_pu), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
		.pb_pullup_en(pb_pu), .divider_out(div_o), .pwm_out(pwm_o),
		.option_rc_plus_crystal(opt), .divider_clock_source(dcs), .pwm_type_select(pts),
		.crystal_low_power(clp), .system_clock_select(scs), .internal_rc_enable(rce),
		.sleep_mode(slp), .wake_pulse(wk));
	iop_pin_model #(.W(8)) u_pa (.clk(hclk), .drv(pa_out), .oe(pa_oe), .pull(pa_pu),
		.ext(pa_ext), .ext_en(pa_en), .pin(pa_in));
	iop_pin_model #(.W(2)) u_pb (.clk(hclk), .drv(pb_out), .oe(pb_oe), .pull(pb_pu),
		.ext(2'h0), .ext_en(2'h0), .pin(pb_in));
	task results;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task tick;
		@(posedge hclk);
		#1;
	endtask
	// Ready is judged on the copy taken at the edge, never mid-step
	task wait_rdy;
		int i;
		i = 0;
		tick;
		while (rdy_q !== 1'b1) begin
			i++;
			if (i > 20) begin
				bad_count++;
				results;
			end
			tick;
		end
	endtask
	task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
		hsel <= 1;
		haddr <= a;
		htrans <= IOP_HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		rd = rd_q;
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task rdc(input string n, input logic [31:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		chk(n, e, rd);
	endtask
	initial begin
		int n;
		repeat (12) @(posedge hclk);
		hresetn <= 1;
		tick;
		chk("pa_oe reset", 0, pa_oe);
		chk("rc reset", 1, rce);
		rdc("ctl reset", 32'h1c, 0);
		rdc("dir reset", 32'h04, 32'hff);
		wr(32'h04, 32'h0f);
		wr(32'h00, 32'ha5);
		pa_en <= 8'h0f;
		pa_ext <= 8'h06;
		chk("pa_oe", 8'hf0, pa_oe);
		chk("pa_out", 8'ha5, pa_out);
		repeat (3) tick;
		rdc("pa pins", 32'h00, 32'ha6);
		wr(32'h44, 32'h10);
		wr(32'h80, 32'h20);
		rdc("dir set", 32'h04, 32'h1f);
		chk("pa_out clear", 8'h85, pa_out);
		chk("pa_oe turned", 8'he0, pa_oe);
		wr(32'h0c, 32'hff);
		wr(32'h18, 32'h03);
		chk("pa pull", 8'h1f, pa_pu);
		chk("pb pull", 2'h3, pb_pu);
		for (int i = 0; i < 8; i++) begin
			wr(32'h1c, 32'h1 << i);
			rdc("ctl read", 32'h1c, (32'h1 << i) & 32'h6f);
			chk("ctl src", {i == 6, i == 5, i == 1}, {dcs, pts, clp});
			chk("ctl clk", {i == 0, i != 0}, {scs, rce});
			chk("pb oe", {i == 3, i == 2}, pb_oe);
			chk("pb out", {i == 3, i == 2}, pb_out);
		end
		wr(32'h14, 32'hf2);
		wr(32'h10, 32'h01);
		chk("pb_oe dir", 2'b01, pb_oe);
		chk("pb pull dir", 2'b10, pb_pu);
		repeat (2) tick;
		rdc("pb pins", 32'h10, 32'h03);
		rdc("pb dir", 32'h14, 32'h02);
		wr(32'h90, 32'h01);
		repeat (2) tick;
		rdc("pb pins low", 32'h10, 32'h02);
		wr(32'h1c, 32'h0c);
		div_o <= 0;
		tick;
		chk("pb div", 2'b10, pb_out);
		chk("pb pull off", 2'b00, pb_pu);
		pwm_o <= 0;
		div_o <= 1;
		tick;
		chk("pb pwm", 2'b01, pb_out);
		pwm_o <= 1;
		opt <= 0;
		wr(32'h1c, 32'h01);
		repeat (3) tick;
		chk("option off", 2'b01, {scs, rce});
		wr(32'h08, 32'h01);
		rdc("wake en", 32'h08, 32'h01);
		pa_ext <= 8'h03;
		wr(32'h20, 32'h01);
		chk("asleep", 1, slp);
		rdc("sleep read", 32'h20, 32'h01);
		pa_ext <= 8'h01;
		repeat (8) tick;
		chk("no wake", 1, slp);
		pa_ext <= 8'h00;
		n = 0;
		while (wk !== 1'b1 && n < 10) begin
			tick;
			n++;
		end
		chk("woke", 2'b10, {wk, slp});
		rdc("awake read", 32'h20, 0);
		wr(32'h24, 32'h55);
		rdc("unmapped", 32'h24, 0);
		rdc("alias read", 32'h44, 0);
		chk("hresp", 0, hresp);
		// Second reset in mid-run, released away from the edge
		hresetn <= 0;
		repeat (2) tick;
		hresetn <= 1;
		tick;
		chk("pa_oe rst2", 0, pa_oe);
		chk("clk rst2", 2'b01, {scs, rce});
		rdc("ctl rst2", 32'h1c, 0);
		rdc("dir rst2", 32'h04, 32'hff);
		results;
	end
endmodule
